// >>> bench/ead_draw_props.sv
// ead_draw_props: port checks of the conic drawer
`timescale 1ns/100ps
module ead_draw_props
    import ead_pkg::*;
#(
    parameter logic [31:0] MAX_STEPS = EAD_MAX_STEPS_DEF
)(
    // clock and reset
    input logic mclk,
    input logic reset,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic pready,
    input logic [31:0] prdata,
    input logic pslverr,
    // pixels and status
    input logic pixValid,
    input ead_pix_t pixOut,
    input logic pixReady,
    input logic busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    // ===================================================================
    // helpers
    function automatic logic near(logic [15:0] d);
        return d == 16'h0000 || d == 16'h0001 || d == 16'hFFFF;
    endfunction

    // ===================================================================
    // properties
    property p_readyCause;
        pready |-> $past(psel && penable);
    endproperty
    a_readyCause: assert property (p_readyCause)
        else $error("pready without access phase");
    property p_readyPulse;
        pready |=> !pready;
    endproperty
    a_readyPulse: assert property (p_readyPulse)
        else $error("pready longer than one cycle");
    property p_errOnly;
        pslverr |-> pready;
    endproperty
    a_errOnly: assert property (p_errOnly)
        else $error("pslverr outside ready cycle");
    property p_rdZero;
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    a_rdZero: assert property (p_rdZero)
        else $error("prdata not zero outside ready cycle");
    property p_pixHold;
        pixValid && !pixReady |=> pixValid && $stable(pixOut);
    endproperty
    a_pixHold: assert property (p_pixHold)
        else $error("pixel changed while stalled");
    property p_pixStep;
        pixValid && pixReady ##1 pixValid |->
            near(pixOut.x - $past(pixOut.x)) &&
            near(pixOut.y - $past(pixOut.y)) && pixOut != $past(pixOut);
    endproperty
    a_pixStep: assert property (p_pixStep)
        else $error("trace step not to a neighbour");
    property p_idleNoPix;
        !busy |-> !pixValid;
    endproperty
    a_idleNoPix: assert property (p_idleNoPix)
        else $error("pixel while idle");
    property p_busyEnd;
        $fell(busy) |-> $past(pixValid && pixReady) && !pixValid;
    endproperty
    a_busyEnd: assert property (p_busyEnd)
        else $error("busy fell without final pixel");
    c_pix: cover property (pixValid && pixReady);
    c_stall: cover property (pixValid && !pixReady);
    c_err: cover property (pslverr);
endmodule

bind ead_draw_top ead_draw_props #(.MAX_STEPS(MAX_STEPS)) u_props (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pixValid(pixValid),
    .pixOut(pixOut), .pixReady(pixReady), .busy(busy)
);

// >>> bench/ead_pix_sink.sv
// ead_pix_sink: frame buffer side taking pixels with random stalls
`timescale 1ns/100ps
module ead_pix_sink
    import ead_pkg::*;
(
    // clock and reset
    input logic mclk,
    input logic reset,
    // pixel stream
    input logic pixValid,
    input ead_pix_t pixOut,
    output logic pixReady,
    // stall control
    input logic stallOn,
    input logic rndBit
);
    // ready may drop at any cycle, as a busy memory would
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pixReady <= 1'b0;
        end else begin
            pixReady <= !stallOn || rndBit;
        end
    end
endmodule

// >>> bench/tb_ellipse_and_abs_arc_draw.sv
// tb_ellipse_and_abs_arc_draw: random and corner cases of the conic drawer
`timescale 1ns/100ps
module tb_ellipse_and_abs_arc_draw
    import ead_pkg::*;
;
    // ===================================================================
    // signals
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic pixValid;
    ead_pix_t pixOut;
    logic pixReady;
    logic busy;
    logic stallOn = 1'b0;
    logic rndBit = 1'b0;
    logic [31:0] seed = 32'h98f7_99b6;
    logic [31:0] rdv;
    logic err;
    logic [7:0] fld;
    logic [31:0] stExp = 32'h0000_0000;
    ead_pix_t pq[$];
    int errors = 0;
    int checks = 0;

    ead_draw_top #(.MAX_STEPS(32'h0000_1000)) dut (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .pixValid(pixValid),
        .pixOut(pixOut), .pixReady(pixReady), .busy(busy)
    );
    ead_pix_sink u_sink (
        .mclk(mclk), .reset(reset), .pixValid(pixValid), .pixOut(pixOut),
        .pixReady(pixReady), .stallOn(stallOn), .rndBit(rndBit)
    );

    initial begin
        forever #2 mclk = ~mclk;
    end

    // ===================================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int abs(int v);
        return v < 0 ? -v : v;
    endfunction
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        rndBit <= ^rnd();
        if (pixValid === 1'b1 && pixReady === 1'b1) pq.push_back(pixOut);
    end

    // ===================================================================
    // command runs
    task automatic draw(input logic [15:0] cmd, sx, sy,
                        input logic [15:0] p[4], input int np);
        apb(1'b1, EAD_OFS_PTRX, {16'h0000, sx});
        apb(1'b1, EAD_OFS_PTRY, {16'h0000, sy});
        pq.delete();
        apb(1'b1, EAD_OFS_CMD, {16'h0000, cmd});
        for (int i = 0; i < np; i++) begin
            apb(1'b1, EAD_OFS_PARAM, {16'h0000, p[i]});
        end
        while (busy !== 1'b0) begin
            @(posedge mclk);
        end
        apb(1'b0, EAD_OFS_STAT, 32'h0000_0000);
        cmp(rdv, stExp | 32'(np) << EAD_ST_CNT_LO);
    endtask
    task automatic chk(input logic [15:0] cx, cy, input int a, b, rr,
                       input logic [15:0] ex, ey, input int ecnt);
        int rx;
        int ry;
        int cnt;
        cnt = 0;
        foreach (pq[k]) begin
            rx = $signed(16'(pq[k].x - cx));
            ry = $signed(16'(pq[k].y - cy));
            cmp(abs(b * rx * rx + a * ry * ry - rr) <=
                b * (2 * abs(rx) + 1) + a * (2 * abs(ry) + 1), 1);
            cmp({pq[k].area, pq[k].col, pq[k].operation_mode_field}, fld);
            if (pq[k].x == ex && pq[k].y == ey) cnt++;
        end
        cmp(cnt, ecnt);
    endtask
    task automatic ell(input logic cw, input logic [15:0] sx, sy, a, b, dx);
        fld = 8'(rnd());
        draw({8'hAC | 8'(cw), fld}, sx, sy, '{a, b, dx, 16'h0000}, 3);
        chk(sx, sy, a, b, b * dx * dx, 16'(sx + dx), sy, 1);
        cmp(pq[0].x, 16'(sx + dx));
        cmp(pq[0].y, sy);
        cmp(pq[1].y, cw ? 16'(sy - 16'h0001) : 16'(sy + 16'h0001));
        apb(1'b0, EAD_OFS_PTRX, 32'h0000_0000);
        cmp(rdv, {16'h0000, sx});
        apb(1'b0, EAD_OFS_PTRY, 32'h0000_0000);
        cmp(rdv, {16'h0000, sy});
    endtask
    task automatic arc(input logic cw);
        fld = 8'(rnd());
        // upper three bits of each word nonzero, to be ignored
        draw({8'hB0 | 8'(cw), fld}, 16'h000C, 16'h0004,
             '{16'hE00C, 16'h200A, 16'hA006, 16'h600A}, 4);
        chk(16'h000C, 16'h000A, 1, 1, 36, 16'h0006, 16'h000A, 0);
        cmp(pq[0].x, 32'h0000_000C);
        cmp(pq[0].y, 32'h0000_0004);
        cmp(pq[1].x, cw ? 32'h0000_000B : 32'h0000_000D);
        apb(1'b0, EAD_OFS_PTRX, 32'h0000_0000);
        cmp(rdv, 32'h0000_0006);
        apb(1'b0, EAD_OFS_PTRY, 32'h0000_0000);
        cmp(rdv, 32'h0000_000A);
    endtask

    // ===================================================================
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        apb(1'b0, EAD_OFS_PTRY, 32'h0000_0000);
        cmp(rdv, 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0000_0000);
        cmp({rdv[30:0], err}, 32'h0000_0001);
        apb(1'b1, EAD_OFS_CMD, 32'h0000_A400);
        apb(1'b0, EAD_OFS_STAT, 32'h0000_0000);
        cmp(rdv, 32'h0000_0002);
        apb(1'b1, EAD_OFS_STAT, 32'h0000_0002);
        apb(1'b0, EAD_OFS_STAT, 32'h0000_0000);
        cmp(rdv, 32'h0000_0000);
        ell(1'b0, 16'h0010, 16'h000A, 16'h0009, 16'h0004, 16'h0009);
        stallOn <= 1'b1;
        ell(1'b1, 16'h0010, 16'h000A, 16'h0009, 16'h0004, 16'h0009);
        arc(1'b0);
        arc(1'b1);
        // a and b below 6 bits, semi-axis below 4 bits
        repeat (4) begin
            ell(^rnd(), 16'(rnd() % 1024 + 100), 16'(rnd() % 1024 + 100),
                16'(rnd() % 63 + 1), 16'(rnd() % 63 + 1),
                16'(rnd() % 15 + 1));
        end
        // end point off the circle: trace runs to the step limit
        stExp = 32'h0000_0004;
        draw(16'hB000, 16'h0000, 16'hFFFE,
             '{16'h0000, 16'h0000, 16'h0003, 16'h0000}, 4);
        apb(1'b1, EAD_OFS_STAT, 32'h0000_0004);
        apb(1'b0, EAD_OFS_STAT, 32'h0000_0000);
        cmp(rdv, 32'h0000_0040);
        finish_test();
    end

    initial begin
        #200000;
        errors++;
        finish_test();
    end
endmodule

// >>> rtl/ead_conic_eval.sv
// ead_conic_eval: residual b*x^2 + a*y^2 - r of a centred conic
`timescale 1ns/100ps
module ead_conic_eval
    import ead_pkg::*;
(
    // coefficients
    input logic [15:0] coefA,
    input logic [15:0] coefB,
    // point relative to centre
    input logic signed [EAD_RW-1:0] relX,
    input logic signed [EAD_RW-1:0] relY,
    // constant term
    input logic signed [EAD_FW-1:0] radSq,
    // residual
    output logic signed [EAD_FW-1:0] resid
);
    logic signed [2*EAD_RW-1:0] xSq;
    logic signed [2*EAD_RW-1:0] ySq;
    logic signed [EAD_FW-1:0] xSqW;
    logic signed [EAD_FW-1:0] ySqW;
    logic signed [EAD_FW-1:0] aW;
    logic signed [EAD_FW-1:0] bW;
    logic signed [EAD_FW-1:0] termX;
    logic signed [EAD_FW-1:0] termY;

    assign xSq = relX * relX;
    assign ySq = relY * relY;
    assign xSqW = {{(EAD_FW-2*EAD_RW){xSq[2*EAD_RW-1]}}, xSq};
    assign ySqW = {{(EAD_FW-2*EAD_RW){ySq[2*EAD_RW-1]}}, ySq};
    assign aW = {{(EAD_FW-16){1'b0}}, coefA};
    assign bW = {{(EAD_FW-16){1'b0}}, coefB};
    assign termX = xSqW * bW;
    assign termY = ySqW * aW;
    assign resid = termX + termY - radSq;
endmodule

// >>> rtl/ead_draw_top.sv
// ead_draw_top: ellipse and absolute arc command engine with apb registers
// Function
// RL1: ellipse opcode in bits 15:9, bit 8 direction, low bits area/col/mode
// RL2: ellipse takes ratio a, ratio b, x semi-axis after the command word
// RL3: ellipse traced so b*x^2 + a*y^2 equals b times semi-axis squared
// RL4: pointer first moves by the x semi-axis; that point starts the trace
// RL5: ellipse ends back at its start point, which is not plotted
// RL6: after the ellipse the pointer returns to the centre
// RL7: ellipse bit 8 set draws clockwise, clear draws counterclockwise
// RL8: host keeps bit length of a or b plus semi-axis within 13
// RL9: absolute arc opcode in bits 15:9, bit 8 direction, low fields shared
// RL10: arc takes centre x, centre y, end x, end y after the command
// RL11: arc runs from the pointer to the end point about the given centre
// RL12: pointer ends at the arc end point, which is not plotted
// RL13: arc bit 8 set draws clockwise, clear draws counterclockwise
// RL14: arc parameters use only their low 13 bits
// RL15: each pixel carries area, colour source and mode for downstream use
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module ead_draw_top
    import ead_pkg::*;
#(
    parameter logic [31:0] MAX_STEPS = EAD_MAX_STEPS_DEF
)(
    // clock and reset
    input logic mclk,
    input logic reset,
    // apb slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // pixel stream
    output logic pixValid,
    output ead_pix_t pixOut,
    input logic pixReady,
    // status
    output logic busy
);
    typedef struct packed {
        ead_fsm_t fsm;
        logic isArc;
        logic cw;
        logic [2:0] area;
        logic [1:0] col;
        logic [2:0] operation_mode_field;
        logic [3:0][15:0] prm;
        logic [2:0] prmCnt;
        logic [2:0] prmNeed;
        logic signed [15:0] ptrX;
        logic signed [15:0] ptrY;
        logic signed [15:0] cenX;
        logic signed [15:0] cenY;
        logic signed [EAD_RW-1:0] relX;
        logic signed [EAD_RW-1:0] relY;
        logic signed [EAD_RW-1:0] endX;
        logic signed [EAD_RW-1:0] endY;
        logic [15:0] coefA;
        logic [15:0] coefB;
        logic signed [EAD_FW-1:0] radSq;
        logic [31:0] steps;
        logic errOpc;
        logic errAbort;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic pixValid;
        ead_pix_t pix;
        logic busy;
    } ead_state_t;

    ead_state_t s_r;
    ead_state_t s_nxt;

    // =====================================================================
    // helpers
    function automatic logic signed [15:0] sext13(input logic [15:0] w);
        sext13 = {{(16-EAD_COORD_BITS){w[EAD_COORD_BITS-1]}},
                  w[EAD_COORD_BITS-1:0]};
    endfunction

    function automatic logic [15:0] absCoord(
        input logic signed [15:0] cen,
        input logic signed [EAD_RW-1:0] rel
    );
        logic [EAD_RW-1:0] sum;
        sum = {cen[15], cen} + rel;
        absCoord = sum[15:0];
    endfunction

    function automatic logic signed [EAD_RW-1:0] sgn(
        input logic signed [2*EAD_RW-1:0] v
    );
        if (v > 0) begin
            sgn = 17'sh0_0001;
        end else if (v < 0) begin
            sgn = -17'sh0_0001;
        end else begin
            sgn = 17'sh0_0000;
        end
    endfunction

    // =====================================================================
    // setup values
    logic signed [15:0] supCenX;
    logic signed [15:0] supCenY;
    logic signed [EAD_RW-1:0] supRelX;
    logic signed [EAD_RW-1:0] supRelY;
    logic signed [EAD_RW-1:0] supEndX;
    logic signed [EAD_RW-1:0] supEndY;
    logic [15:0] supA;
    logic [15:0] supB;

    always_comb begin
        if (s_r.isArc) begin
            supCenX = sext13(s_r.prm[0]); // [RL14]
            supCenY = sext13(s_r.prm[1]); // [RL14]
            supRelX = {s_r.ptrX[15], s_r.ptrX} - {supCenX[15], supCenX};
            supRelY = {s_r.ptrY[15], s_r.ptrY} - {supCenY[15], supCenY};
            supEndX = {s_r.prm[2][EAD_COORD_BITS-1], sext13(s_r.prm[2])}
                      - {supCenX[15], supCenX}; // [RL11]
            supEndY = {s_r.prm[3][EAD_COORD_BITS-1], sext13(s_r.prm[3])}
                      - {supCenY[15], supCenY}; // [RL11]
            supA = 16'h0001;
            supB = 16'h0001;
        end else begin
            supCenX = s_r.ptrX;
            supCenY = s_r.ptrY;
            supRelX = {4'h0, s_r.prm[2][EAD_COORD_BITS-1:0]}; // [RL4]
            supRelY = 17'sh0_0000;
            supEndX = supRelX; // [RL5]
            supEndY = supRelY;
            supA = s_r.prm[0]; // [RL2]
            supB = s_r.prm[1]; // [RL2]
        end
    end

    // =====================================================================
    // step selection along the conic tangent
    logic signed [2*EAD_RW-1:0] tx;
    logic signed [2*EAD_RW-1:0] ty;
    logic signed [2*EAD_RW-1:0] absTx;
    logic signed [2*EAD_RW-1:0] absTy;
    logic signed [EAD_RW-1:0] stX;
    logic signed [EAD_RW-1:0] stY;
    logic signed [EAD_RW-1:0] primX;
    logic signed [EAD_RW-1:0] primY;
    logic signed [EAD_RW-1:0] diagX;
    logic signed [EAD_RW-1:0] diagY;
    logic signed [EAD_RW-1:0] nxtX;
    logic signed [EAD_RW-1:0] nxtY;
    logic signed [EAD_FW-1:0] residP;
    logic signed [EAD_FW-1:0] residD;
    logic signed [EAD_FW-1:0] absP;
    logic signed [EAD_FW-1:0] absD;
    logic [15:0] evA;
    logic [15:0] evB;
    logic signed [EAD_RW-1:0] evX;
    logic signed [EAD_RW-1:0] evY;
    logic signed [EAD_FW-1:0] evR;

    always_comb begin
        // counterclockwise tangent is (-a*y, b*x); clockwise negates it
        tx = $signed({1'b0, s_r.coefA}) * s_r.relY;
        ty = $signed({1'b0, s_r.coefB}) * s_r.relX;
        if (!s_r.cw) begin
            tx = -tx; // [RL7] [RL13]
        end else begin
            ty = -ty; // [RL7] [RL13]
        end
        absTx = (tx < 0) ? -tx : tx;
        absTy = (ty < 0) ? -ty : ty;
        stX = sgn(tx);
        stY = sgn(ty);
        diagX = s_r.relX + stX;
        diagY = s_r.relY + stY;
        if (absTx >= absTy) begin
            primX = s_r.relX + stX;
            primY = s_r.relY;
        end else begin
            primX = s_r.relX;
            primY = s_r.relY + stY;
        end
        absP = (residP < 0) ? -residP : residP;
        absD = (residD < 0) ? -residD : residD;
        // nearest candidate to the curve wins
        if (absP <= absD) begin
            nxtX = primX; // [RL3] [RL11]
            nxtY = primY;
        end else begin
            nxtX = diagX; // [RL3] [RL11]
            nxtY = diagY;
        end
    end

    // setup reuses the first evaluator to form the constant term
    always_comb begin
        if (s_r.fsm == EAD_SETUP) begin
            evA = supA;
            evB = supB;
            evX = supRelX;
            evY = supRelY;
            evR = '0;
        end else begin
            evA = s_r.coefA;
            evB = s_r.coefB;
            evX = primX;
            evY = primY;
            evR = s_r.radSq;
        end
    end

    ead_conic_eval u_evalPrim (
        .coefA(evA),
        .coefB(evB),
        .relX(evX),
        .relY(evY),
        .radSq(evR),
        .resid(residP)
    );

    ead_conic_eval u_evalDiag (
        .coefA(s_r.coefA),
        .coefB(s_r.coefB),
        .relX(diagX),
        .relY(diagY),
        .radSq(s_r.radSq),
        .resid(residD)
    );

    // =====================================================================
    // apb decode
    logic apbAcc;
    logic apbHit;
    logic wrFire;
    logic [31:0] rdData;
    logic [6:0] opc;

    always_comb begin
        apbAcc = psel && penable;
        apbHit = 1'b1;
        rdData = '0;
        unique case (paddr)
            EAD_OFS_CMD: rdData = '0;
            EAD_OFS_PARAM: rdData = '0;
            EAD_OFS_PTRX: rdData = {16'h0000, s_r.ptrX};
            EAD_OFS_PTRY: rdData = {16'h0000, s_r.ptrY};
            EAD_OFS_STAT: begin
                rdData[EAD_ST_BUSY] = (s_r.fsm != EAD_IDLE);
                rdData[EAD_ST_ERR_OPC] = s_r.errOpc;
                rdData[EAD_ST_ERR_ABORT] = s_r.errAbort;
                rdData[EAD_ST_WAITPRM] = (s_r.fsm == EAD_PARAM);
                rdData[EAD_ST_CNT_HI:EAD_ST_CNT_LO] = s_r.prmCnt;
            end
            default: apbHit = 1'b0;
        endcase
        wrFire = apbAcc && s_r.pready && pwrite && apbHit;
        opc = pwdata[EAD_OPC_HI:EAD_OPC_LO];
    end

    // =====================================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        // one wait state, write takes effect on the completing edge
        if (apbAcc && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = pwrite ? 32'h0000_0000 : rdData;
            s_nxt.pslverr = !apbHit;
        end else begin
            s_nxt.pready = 1'b0;
            s_nxt.prdata = '0;
            s_nxt.pslverr = 1'b0;
        end

        if (wrFire && paddr == EAD_OFS_STAT) begin
            if (pwdata[EAD_ST_ERR_OPC]) begin
                s_nxt.errOpc = 1'b0;
            end
            if (pwdata[EAD_ST_ERR_ABORT]) begin
                s_nxt.errAbort = 1'b0;
            end
        end

        unique case (s_r.fsm)
            EAD_IDLE, EAD_PARAM: begin
                if (wrFire && paddr == EAD_OFS_PTRX) begin
                    s_nxt.ptrX = pwdata[15:0];
                end
                if (wrFire && paddr == EAD_OFS_PTRY) begin
                    s_nxt.ptrY = pwdata[15:0];
                end
                if (wrFire && paddr == EAD_OFS_CMD) begin
                    s_nxt.cw = pwdata[EAD_DIR_BIT]; // [RL1] [RL9]
                    s_nxt.area = pwdata[EAD_AREA_HI:EAD_AREA_LO]; // [RL15]
                    s_nxt.col = pwdata[EAD_COL_HI:EAD_COL_LO]; // [RL15]
                    s_nxt.operation_mode_field = pwdata[EAD_OPM_HI:EAD_OPM_LO]; // [RL15]
                    s_nxt.prmCnt = 3'h0;
                    if (opc == EAD_OPC_ELLIPSE) begin
                        s_nxt.isArc = 1'b0; // [RL1]
                        s_nxt.prmNeed = EAD_NPRM_ELLIPSE; // [RL2]
                        s_nxt.fsm = EAD_PARAM;
                    end else if (opc == EAD_OPC_ARC) begin
                        s_nxt.isArc = 1'b1; // [RL9]
                        s_nxt.prmNeed = EAD_NPRM_ARC; // [RL10]
                        s_nxt.fsm = EAD_PARAM;
                    end else begin
                        s_nxt.errOpc = 1'b1;
                        s_nxt.fsm = EAD_IDLE;
                    end
                end else if (wrFire && paddr == EAD_OFS_PARAM &&
                             s_r.fsm == EAD_PARAM) begin
                    s_nxt.prm[s_r.prmCnt[1:0]] = pwdata[15:0]; // [RL2] [RL10]
                    s_nxt.prmCnt = s_r.prmCnt + 3'h1;
                    if (s_r.prmCnt + 3'h1 == s_r.prmNeed) begin
                        s_nxt.fsm = EAD_SETUP;
                    end
                end
            end
            EAD_SETUP: begin
                s_nxt.cenX = supCenX;
                s_nxt.cenY = supCenY;
                s_nxt.relX = supRelX;
                s_nxt.relY = supRelY;
                s_nxt.endX = supEndX;
                s_nxt.endY = supEndY;
                s_nxt.coefA = supA;
                s_nxt.coefB = supB;
                s_nxt.radSq = residP; // [RL3]
                s_nxt.steps = '0;
                if (!s_r.isArc) begin
                    s_nxt.ptrX = absCoord(supCenX, supRelX); // [RL4]
                end
                s_nxt.pix.x = absCoord(supCenX, supRelX);
                s_nxt.pix.y = absCoord(supCenY, supRelY);
                s_nxt.pix.area = s_r.area; // [RL15]
                s_nxt.pix.col = s_r.col;
                s_nxt.pix.operation_mode_field = s_r.operation_mode_field;
                s_nxt.pixValid = 1'b1;
                s_nxt.fsm = EAD_PLOT;
            end
            EAD_PLOT: begin
                if (s_r.pixValid && pixReady) begin
                    s_nxt.relX = nxtX;
                    s_nxt.relY = nxtY;
                    s_nxt.steps = s_r.steps + 32'h0000_0001;
                    if (nxtX == s_r.endX && nxtY == s_r.endY) begin
                        // closing point itself is never plotted
                        s_nxt.pixValid = 1'b0; // [RL5] [RL12]
                        s_nxt.fsm = EAD_IDLE;
                        if (s_r.isArc) begin
                            s_nxt.ptrX = absCoord(s_r.cenX, s_r.endX); // [RL12]
                            s_nxt.ptrY = absCoord(s_r.cenY, s_r.endY); // [RL12]
                        end else begin
                            s_nxt.ptrX = s_r.cenX; // [RL6]
                            s_nxt.ptrY = s_r.cenY; // [RL6]
                        end
                    end else if (s_r.steps + 32'h0000_0001 >= MAX_STEPS) begin
                        // runaway trace, leave pointer on last plotted point
                        s_nxt.pixValid = 1'b0;
                        s_nxt.errAbort = 1'b1;
                        s_nxt.fsm = EAD_IDLE;
                        s_nxt.ptrX = absCoord(s_r.cenX, s_r.relX);
                        s_nxt.ptrY = absCoord(s_r.cenY, s_r.relY);
                    end else begin
                        s_nxt.pix.x = absCoord(s_r.cenX, nxtX);
                        s_nxt.pix.y = absCoord(s_r.cenY, nxtY);
                    end
                end
            end
        endcase
        s_nxt.busy = (s_nxt.fsm != EAD_IDLE);
    end

    // =====================================================================
    // state register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
            s_r.fsm <= EAD_IDLE;
            s_r.ptrX <= EAD_PTR_RST;
            s_r.ptrY <= EAD_PTR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =====================================================================
    // outputs
    assign pready = s_r.pready;
    assign prdata = s_r.prdata;
    assign pslverr = s_r.pslverr;
    assign pixValid = s_r.pixValid;
    assign pixOut = s_r.pix;
    assign busy = s_r.busy;
endmodule

// >>> rtl/ead_pkg.sv
// ead_pkg: register map, command fields and carrier types of the conic drawer
package ead_pkg;

    // =====================================================================
    // register offsets (byte addresses)
    localparam logic [7:0] EAD_OFS_CMD = 8'h00;
    localparam logic [7:0] EAD_OFS_PARAM = 8'h04;
    localparam logic [7:0] EAD_OFS_PTRX = 8'h08;
    localparam logic [7:0] EAD_OFS_PTRY = 8'h0C;
    localparam logic [7:0] EAD_OFS_STAT = 8'h10;

    // =====================================================================
    // command word fields
    localparam int EAD_OPC_HI = 15;
    localparam int EAD_OPC_LO = 9;
    localparam int EAD_DIR_BIT = 8;
    localparam int EAD_AREA_HI = 7;
    localparam int EAD_AREA_LO = 5;
    localparam int EAD_COL_HI = 4;
    localparam int EAD_COL_LO = 3;
    localparam int EAD_OPM_HI = 2;
    localparam int EAD_OPM_LO = 0;
    localparam logic [6:0] EAD_OPC_ELLIPSE = 7'h56;
    localparam logic [6:0] EAD_OPC_ARC = 7'h58;
    localparam logic [2:0] EAD_NPRM_ELLIPSE = 3'h3;
    localparam logic [2:0] EAD_NPRM_ARC = 3'h4;
    localparam int EAD_COORD_BITS = 13;

    // =====================================================================
    // status register fields
    localparam int EAD_ST_BUSY = 0;
    localparam int EAD_ST_ERR_OPC = 1;
    localparam int EAD_ST_ERR_ABORT = 2;
    localparam int EAD_ST_WAITPRM = 3;
    localparam int EAD_ST_CNT_LO = 4;
    localparam int EAD_ST_CNT_HI = 6;

    // =====================================================================
    // reset values and limits
    localparam logic [15:0] EAD_PTR_RST = 16'h0000;
    localparam logic [31:0] EAD_MAX_STEPS_DEF = 32'h0002_0000;

    // =====================================================================
    // datapath widths
    localparam int EAD_RW = 17;
    localparam int EAD_FW = 52;

    // =====================================================================
    // types
    typedef enum logic [1:0] {
        EAD_IDLE = 2'b00,
        EAD_PARAM = 2'b01,
        EAD_SETUP = 2'b10,
        EAD_PLOT = 2'b11
    } ead_fsm_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [2:0] area;
        logic [1:0] col;
        logic [2:0] operation_mode_field;
    } ead_pix_t;

endpackage
